// file: hw/srent_pkg.sv
package srent_pkg;
  localparam logic [7:0]  LEAF_ENTRY        = 8'h02;
  localparam logic [7:0]  LEAF_SAVE_DEC     = 8'h09;
  localparam logic [15:0] FAULT_CODE_ZERO   = 16'h0000;
  localparam int          PAGE_ALIGN_BITS   = 12;
  localparam logic [63:0] FEATURE_MASK_BASE = 64'h0000_0000_0000_0003;
  localparam logic [63:0] PERF_STATUS_RESET = 64'h0;
  localparam int          PERF_STATUS_FRZ   = 60;
  localparam int          PERF_STATUS_SUPP  = 63;

  typedef enum logic [1:0] {SRENT_FLT_NONE, SRENT_FLT_GP, SRENT_FLT_PF} srent_fault_t;

  // Thread control page fields needed by the checks
  typedef struct packed {
    logic [63:0] flags_reserved;
    logic        debug_opt_in_flag;
    logic        exit_notify_flag;
    logic [31:0] save_frame_index;
    logic [31:0] save_frame_count;
    logic [63:0] entry_offset;
    logic [63:0] fs_base_offset;
    logic [63:0] gs_base_offset;
    logic [31:0] fs_limit_field;
    logic [31:0] gs_limit_field;
    logic        busy;
    logic        valid;
  } srent_tcp_t;

  // Region control page attributes
  typedef struct packed {
    logic [63:0] base_addr;
    logic [63:0] feature_mask;
    logic        wide_mode_attribute;
    logic        exit_notify_flag;
    logic        in_use;
    logic        cfp_enabled;
  } srent_rcp_t;

  // Core architectural state
  typedef struct packed {
    logic        region_mode;
    logic        wide_mode;
    logic        legacy_float_save_enable;
    logic        extended_save_enable;
    logic [63:0] enabled_features_register;
    logic        seg_bases_nonzero;
    logic [31:0] cs_limit;
    logic [31:0] ds_limit;
    logic        trap_flag;
    logic [63:0] stack_ptr;
    logic [63:0] frame_ptr;
    logic [63:0] fs_base;
    logic [63:0] gs_base;
  } srent_arch_t;

  // Page check results from the memory pipeline
  typedef struct packed {
    logic tcp_page_ok;
    logic frame_pages_ok;
    logic cfp_frame_ok;
    logic tcp_conflict;
  } srent_pchk_t;
endpackage

// file: hw/srent_core.sv
`timescale 1ns/1ps
module srent_core #(
  parameter int ADDR_W = 64                              // Linear address width
) (
  input  wire logic                  sys_clk_in,        // Core clock
  input  wire logic                  rst_in,            // Sync reset, high
  input  wire logic                  clk_en_in,         // Freezes state when low
  input  wire logic                  issue_in,          // Leaf issued, one cycle
  input  wire logic [7:0]            leaf_code_in,      // Accumulator function code
  input  wire logic [63:0]           reg_b_in,          // Control page address
  input  wire logic [63:0]           reg_c_in,          // Async exit pointer
  input  wire logic [63:0]           next_ip_in,        // Address after the leaf
  input  wire logic                  drained_in,        // Prior work complete
  input  wire srent_pkg::srent_tcp_t  tcp_in,            // Thread control page
  input  wire srent_pkg::srent_rcp_t  rcp_in,            // Region control page
  input  wire srent_pkg::srent_arch_t arch_in,           // Current arch state
  input  wire srent_pkg::srent_pchk_t pchk_in,           // Page check results
  output logic                       done_out,          // Leaf finished, pulse
  output srent_pkg::srent_fault_t    fault_out,         // Fault kind with done
  output logic [15:0]                fault_code_out,    // Fault error code
  output logic [63:0]                ret_a_out,         // Returned save frame index
  output logic [63:0]                ret_c_out,         // Returned next address
  output logic                       region_mode_out,   // Executing in region
  output logic [63:0]                ip_out,            // New instruction pointer
  output logic [31:0]                save_index_out,    // Updated save frame index
  output logic [63:0]                saved_sp_out,      // Saved stack pointer
  output logic [63:0]                saved_bp_out,      // Saved frame pointer
  output logic [63:0]                tcp_aep_out,       // Exit pointer stored in page
  output logic [63:0]                saved_fs_out,      // Saved fs base
  output logic [63:0]                saved_gs_out,      // Saved gs base
  output logic [63:0]                new_fs_out,        // New fs base
  output logic [63:0]                new_gs_out,        // New gs base
  output logic [31:0]                new_fs_limit_out,  // New fs limit, narrow mode
  output logic [31:0]                new_gs_limit_out,  // New gs limit, narrow mode
  output logic [63:0]                saved_xfeat_out,   // Saved features register
  output logic [63:0]                xfeat_out,         // Active features register
  output logic                       saved_tf_out,      // Saved trap flag
  output logic                       trap_flag_out,     // Current trap flag
  output logic                       step_pend_out,     // Single step pended
  output logic                       opt_out_out,       // Opt-out entry active
  output logic                       bp_sup_out_out,    // Outside-range code bp off
  output logic                       bp_sup_in_out,     // In-range code/data bp off
  output logic                       perf_sup_out,      // Monitoring suppressed
  output logic                       precise_event_sampling_sup_out,      // Precise sampling off
  output logic                       demote_other_out,  // Demote other threads
  output logic [63:0]                perf_status_out    // Global perf status
);
  if (ADDR_W < 33 || ADDR_W > 64) begin : g_addr_w_check
    $error("ADDR_W must be 33..64");
  end

  typedef enum logic [1:0] {SRENT_IDLE, SRENT_DRAIN} srent_state_t;
  srent_state_t state_reg;
  logic [7:0]   code_reg;
  logic [63:0]  b_reg;
  logic [63:0]  c_reg;
  logic [63:0]  ip_next_reg;

  logic [63:0] target;
  logic [63:0] fs_b;
  logic [63:0] gs_b;
  logic [63:0] fs_l;
  logic [63:0] gs_l;
  logic        opt_in;
  logic        canon_t;
  logic        canon_c;
  srent_pkg::srent_fault_t ent_flt;
  srent_pkg::srent_fault_t dec_flt;

  function automatic logic canon(input logic [63:0] a);
    canon = (a[63:ADDR_W-1] == '0) || (a[63:ADDR_W-1] == '1);
  endfunction

  assign target  = tcp_in.entry_offset + rcp_in.base_addr;
  assign fs_b    = tcp_in.fs_base_offset + rcp_in.base_addr;
  assign gs_b    = tcp_in.gs_base_offset + rcp_in.base_addr;
  assign fs_l    = fs_b + {32'h0, tcp_in.fs_limit_field};
  assign gs_l    = gs_b + {32'h0, tcp_in.gs_limit_field};
  assign opt_in  = tcp_in.debug_opt_in_flag;
  assign canon_t = canon(target);
  assign canon_c = canon(c_reg);

  always_comb begin
    ent_flt = srent_pkg::SRENT_FLT_NONE;
    if (b_reg[srent_pkg::PAGE_ALIGN_BITS-1:0] != '0) begin
      ent_flt = srent_pkg::SRENT_FLT_GP;
    end else if (!pchk_in.tcp_page_ok || !tcp_in.valid) begin
      ent_flt = srent_pkg::SRENT_FLT_PF;
    end else if (pchk_in.tcp_conflict || tcp_in.busy || rcp_in.in_use) begin
      ent_flt = srent_pkg::SRENT_FLT_GP;
    end else if (tcp_in.flags_reserved != '0) begin
      ent_flt = srent_pkg::SRENT_FLT_GP;
    end else if (arch_in.wide_mode != rcp_in.wide_mode_attribute) begin
      ent_flt = srent_pkg::SRENT_FLT_GP;
    end else if (!arch_in.wide_mode && arch_in.seg_bases_nonzero) begin
      ent_flt = srent_pkg::SRENT_FLT_GP;
    end else if (!arch_in.legacy_float_save_enable) begin
      ent_flt = srent_pkg::SRENT_FLT_GP;
    end else if (arch_in.extended_save_enable
                 ? ((rcp_in.feature_mask & arch_in.enabled_features_register)
                    != rcp_in.feature_mask)
                 : (rcp_in.feature_mask != srent_pkg::FEATURE_MASK_BASE)) begin
      ent_flt = srent_pkg::SRENT_FLT_GP;
    end else if (!opt_in && tcp_in.exit_notify_flag != rcp_in.exit_notify_flag) begin
      ent_flt = srent_pkg::SRENT_FLT_GP;
    end else if (tcp_in.save_frame_index >= tcp_in.save_frame_count) begin
      ent_flt = srent_pkg::SRENT_FLT_GP;
    end else if (!pchk_in.frame_pages_ok) begin
      ent_flt = srent_pkg::SRENT_FLT_PF;
    end else if (arch_in.wide_mode ? !canon_t : (target[63:32] != '0 ||
                 target[31:0] > arch_in.cs_limit)) begin
      ent_flt = srent_pkg::SRENT_FLT_GP;
    end else if (arch_in.wide_mode && !canon_c) begin
      ent_flt = srent_pkg::SRENT_FLT_GP;
    end else if (!arch_in.wide_mode &&
                 (fs_l[31:0] > arch_in.ds_limit || gs_l[31:0] > arch_in.ds_limit)) begin
      ent_flt = srent_pkg::SRENT_FLT_GP;
    end else if (arch_in.wide_mode && (!canon(fs_b) || !canon(gs_b))) begin
      ent_flt = srent_pkg::SRENT_FLT_GP;
    end
  end

  always_comb begin
    dec_flt = srent_pkg::SRENT_FLT_NONE;
    if (!arch_in.region_mode || tcp_in.save_frame_index == '0) begin
      dec_flt = srent_pkg::SRENT_FLT_GP;
    end else if (pchk_in.tcp_conflict) begin
      dec_flt = srent_pkg::SRENT_FLT_GP;
    end else if (!pchk_in.frame_pages_ok) begin
      dec_flt = srent_pkg::SRENT_FLT_PF;
    end else if (rcp_in.cfp_enabled && !pchk_in.cfp_frame_ok) begin
      dec_flt = srent_pkg::SRENT_FLT_PF;
    end
  end

  wire logic is_entry = (code_reg == srent_pkg::LEAF_ENTRY);
  wire logic fire     = (state_reg == SRENT_DRAIN) && drained_in;
  wire srent_pkg::srent_fault_t flt = is_entry ? ent_flt : dec_flt;
  wire logic ok_entry = fire && is_entry && (ent_flt == srent_pkg::SRENT_FLT_NONE);
  wire logic ok_dec   = fire && !is_entry && (dec_flt == srent_pkg::SRENT_FLT_NONE);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_reg   <= SRENT_IDLE;
      code_reg    <= 8'h00;
      b_reg       <= 64'h0;
      c_reg       <= 64'h0;
      ip_next_reg <= 64'h0;
    end else if (clk_en_in) begin
      unique case (state_reg)
        SRENT_IDLE: begin
          if (issue_in && (leaf_code_in == srent_pkg::LEAF_ENTRY ||
                           leaf_code_in == srent_pkg::LEAF_SAVE_DEC)) begin
            state_reg   <= SRENT_DRAIN;
            code_reg    <= leaf_code_in;
            b_reg       <= reg_b_in;
            c_reg       <= reg_c_in;
            ip_next_reg <= next_ip_in;
          end
        end
        SRENT_DRAIN: begin
          if (drained_in) state_reg <= SRENT_IDLE;
        end
        default: state_reg <= SRENT_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      done_out       <= 1'b0;
      fault_out      <= srent_pkg::SRENT_FLT_NONE;
      fault_code_out <= srent_pkg::FAULT_CODE_ZERO;
      ret_a_out      <= 64'h0;
      ret_c_out      <= 64'h0;
      step_pend_out  <= 1'b0;
    end else if (clk_en_in) begin
      done_out      <= fire;
      step_pend_out <= 1'b0;
      if (fire) begin
        fault_out      <= flt;
        fault_code_out <= srent_pkg::FAULT_CODE_ZERO;
      end
      if (ok_entry) begin
        ret_a_out <= {32'h0, tcp_in.save_frame_index};
        ret_c_out <= ip_next_reg;
        step_pend_out <= opt_in;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      region_mode_out  <= 1'b0;
      ip_out           <= 64'h0;
      save_index_out   <= 32'h0;
      saved_sp_out     <= 64'h0;
      saved_bp_out     <= 64'h0;
      tcp_aep_out      <= 64'h0;
      saved_fs_out     <= 64'h0;
      saved_gs_out     <= 64'h0;
      new_fs_out       <= 64'h0;
      new_gs_out       <= 64'h0;
      new_fs_limit_out <= 32'h0;
      new_gs_limit_out <= 32'h0;
      saved_xfeat_out  <= 64'h0;
      xfeat_out        <= 64'h0;
      saved_tf_out     <= 1'b0;
      trap_flag_out    <= 1'b0;
    end else if (clk_en_in) begin
      trap_flag_out <= arch_in.trap_flag && !(region_mode_out && opt_out_out);
      xfeat_out     <= arch_in.enabled_features_register;
      if (ok_entry) begin
        region_mode_out <= 1'b1;
        ip_out          <= target;
        save_index_out  <= tcp_in.save_frame_index;
        saved_sp_out    <= arch_in.stack_ptr;
        saved_bp_out    <= arch_in.frame_ptr;
        tcp_aep_out     <= c_reg;
        saved_fs_out    <= arch_in.fs_base;
        saved_gs_out    <= arch_in.gs_base;
        new_fs_out      <= fs_b;
        new_gs_out      <= gs_b;
        if (!arch_in.wide_mode) begin
          new_fs_limit_out <= tcp_in.fs_limit_field;
          new_gs_limit_out <= tcp_in.gs_limit_field;
        end
        if (arch_in.extended_save_enable) begin
          saved_xfeat_out <= arch_in.enabled_features_register;
          xfeat_out       <= rcp_in.feature_mask;
        end
        saved_tf_out <= arch_in.trap_flag;
        if (!opt_in) trap_flag_out <= 1'b0;
      end else if (ok_dec) begin
        save_index_out <= tcp_in.save_frame_index - 32'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      opt_out_out      <= 1'b0;
      bp_sup_out_out   <= 1'b0;
      bp_sup_in_out    <= 1'b0;
      perf_sup_out     <= 1'b0;
      precise_event_sampling_sup_out     <= 1'b0;
      demote_other_out <= 1'b0;
      perf_status_out  <= srent_pkg::PERF_STATUS_RESET;
    end else if (clk_en_in && ok_entry) begin
      opt_out_out      <= !opt_in;
      bp_sup_out_out   <= 1'b1;
      bp_sup_in_out    <= !opt_in;
      perf_sup_out     <= !opt_in;
      precise_event_sampling_sup_out     <= !opt_in;
      demote_other_out <= !opt_in;
      if (!opt_in) begin
        perf_status_out[srent_pkg::PERF_STATUS_FRZ]  <= 1'b1;
        perf_status_out[srent_pkg::PERF_STATUS_SUPP] <= 1'b1;
      end
    end
  end
endmodule

// file: test/srent_checker.sv
`timescale 1ns/1ps
module srent_checker (
  input wire logic                    sys_clk_in,
  input wire logic                    rst_in,
  input wire logic                    clk_en_in,
  input wire logic                    issue_in,
  input wire logic [7:0]              leaf_code_in,
  input wire logic [63:0]             reg_c_in,
  input wire logic [63:0]             next_ip_in,
  input wire logic                    drained_in,
  input wire srent_pkg::srent_tcp_t   tcp_in,
  input wire srent_pkg::srent_rcp_t   rcp_in,
  input wire srent_pkg::srent_arch_t  arch_in,
  input wire logic                    done_out,
  input wire srent_pkg::srent_fault_t fault_out,
  input wire logic [15:0]             fault_code_out,
  input wire logic [63:0]             ret_c_out,
  input wire logic                    region_mode_out,
  input wire logic [63:0]             ip_out,
  input wire logic [63:0]             tcp_aep_out,
  input wire logic                    trap_flag_out,
  input wire logic                    step_pend_out,
  input wire logic                    opt_out_out,
  input wire logic                    bp_sup_out_out,
  input wire logic                    bp_sup_in_out,
  input wire logic                    perf_sup_out,
  input wire logic [63:0]             perf_status_out
);
  logic        busy_reg;
  logic [7:0]  code_reg;
  logic [63:0] nip_reg;
  logic [63:0] aep_reg;
  logic        take;
  logic        ok_entry;
  assign take = issue_in && clk_en_in && (!busy_reg || done_out) &&
                (leaf_code_in == srent_pkg::LEAF_ENTRY || leaf_code_in == srent_pkg::LEAF_SAVE_DEC);
  assign ok_entry = done_out && fault_out == srent_pkg::SRENT_FLT_NONE &&
                    code_reg == srent_pkg::LEAF_ENTRY;
  // Operands are only valid at issue, so keep them for the late answer
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      busy_reg <= 1'b0;
    end else if (take) begin
      busy_reg <= 1'b1;
    end else if (done_out) begin
      busy_reg <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (take) begin
      code_reg <= leaf_code_in;
      nip_reg  <= next_ip_in;
      aep_reg  <= reg_c_in;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  property p_code_zero; done_out |-> fault_code_out == srent_pkg::FAULT_CODE_ZERO; endproperty
  a_code_zero: assert property (p_code_zero) else $error("nonzero fault code");
  property p_dec_gp;
    done_out && code_reg == srent_pkg::LEAF_SAVE_DEC && (!$past(arch_in.region_mode) ||
      $past(tcp_in.save_frame_index) == 32'h0) |-> fault_out == srent_pkg::SRENT_FLT_GP;
  endproperty
  a_dec_gp: assert property (p_dec_gp) else $error("decrement not refused");
  property p_entry_ok;
    ok_entry |-> region_mode_out && ip_out == $past(rcp_in.base_addr) + $past(tcp_in.entry_offset)
      && ret_c_out == nip_reg && tcp_aep_out == aep_reg;
  endproperty
  a_entry_ok: assert property (p_entry_ok) else $error("bad entry state");
  property p_drain; done_out |-> $past(drained_in) && $past(busy_reg); endproperty
  a_drain: assert property (p_drain) else $error("done before drain");
  property p_keep;
    done_out && fault_out != srent_pkg::SRENT_FLT_NONE |-> $stable(region_mode_out) &&
      $stable(ip_out) && $stable(tcp_aep_out) && $stable(ret_c_out);
  endproperty
  a_keep: assert property (p_keep) else $error("state changed on fault");
  property p_trap; region_mode_out && opt_out_out |-> !trap_flag_out; endproperty
  a_trap: assert property (p_trap) else $error("trap flag set in region");
  property p_step; step_pend_out |-> ok_entry && !opt_out_out; endproperty
  a_step: assert property (p_step) else $error("stray single step");
  property p_bp;
    ok_entry |-> bp_sup_out_out && bp_sup_in_out == opt_out_out &&
      opt_out_out == !$past(tcp_in.debug_opt_in_flag);
  endproperty
  a_bp: assert property (p_bp) else $error("breakpoint suppression wrong");
  property p_perf;
    ok_entry && opt_out_out |-> perf_sup_out && perf_status_out[srent_pkg::PERF_STATUS_FRZ] &&
      perf_status_out[srent_pkg::PERF_STATUS_SUPP];
  endproperty
  a_perf: assert property (p_perf) else $error("monitoring not suppressed");
endmodule
bind srent_core srent_checker u_chk (.sys_clk_in, .rst_in, .clk_en_in, .issue_in,
  .leaf_code_in, .reg_c_in, .next_ip_in, .drained_in, .tcp_in, .rcp_in, .arch_in, .done_out,
  .fault_out, .fault_code_out, .ret_c_out, .region_mode_out, .ip_out, .tcp_aep_out,
  .trap_flag_out, .step_pend_out, .opt_out_out, .bp_sup_out_out, .bp_sup_in_out,
  .perf_sup_out, .perf_status_out);

// file: test/srent_core_tb.sv
`timescale 1ns/1ps
module srent_core_tb;
  logic                    sys_clk_in, rst_in, clk_en_in, issue_in, drained_in, done_out;
  logic [7:0]              leaf_code_in;
  logic [63:0]             reg_b_in, reg_c_in, next_ip_in, ret_a_out, ret_c_out, ip_out;
  srent_pkg::srent_tcp_t   tcp_in;
  srent_pkg::srent_rcp_t   rcp_in;
  srent_pkg::srent_arch_t  arch_in;
  srent_pkg::srent_pchk_t  pchk_in;
  srent_pkg::srent_fault_t fault_out;
  logic                    region_mode_out, trap_flag_out, step_pend_out, opt_out_out;
  logic                    bp_sup_out_out, bp_sup_in_out, perf_sup_out, precise_event_sampling_sup_out;
  logic                    demote_other_out, saved_tf_out;
  logic [15:0]             fault_code_out;
  logic [31:0]             save_index_out, new_fs_limit_out, new_gs_limit_out;
  logic [63:0]             saved_sp_out, saved_bp_out, tcp_aep_out, saved_fs_out, saved_gs_out;
  logic [63:0]             new_fs_out, new_gs_out, saved_xfeat_out, xfeat_out, perf_status_out;
  int                      mismatches, checks_done, k;
  // Zero means any fault kind is acceptable there
  int                      fexp [19] = '{1, 0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 2, 2};

  // Narrow canonical width so a reachable base can be noncanonical
  srent_core #(.ADDR_W(48)) DUT (.sys_clk_in, .rst_in, .clk_en_in, .issue_in, .leaf_code_in,
    .reg_b_in, .reg_c_in, .next_ip_in, .drained_in, .tcp_in, .rcp_in, .arch_in, .pchk_in,
    .done_out, .fault_out, .fault_code_out, .ret_a_out, .ret_c_out, .region_mode_out, .ip_out,
    .save_index_out, .saved_sp_out, .saved_bp_out, .tcp_aep_out, .saved_fs_out, .saved_gs_out,
    .new_fs_out, .new_gs_out, .new_fs_limit_out, .new_gs_limit_out, .saved_xfeat_out,
    .xfeat_out, .saved_tf_out, .trap_flag_out, .step_pend_out, .opt_out_out, .bp_sup_out_out,
    .bp_sup_in_out, .perf_sup_out, .precise_event_sampling_sup_out, .demote_other_out, .perf_status_out);

  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  task automatic check(logic [255:0] got, logic [255:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic defaults(logic wide);
    tcp_in = '{save_frame_index:32'h1, save_frame_count:32'h4, entry_offset:64'h100,
               fs_base_offset:64'h1000, gs_base_offset:64'h2000, fs_limit_field:32'hfff,
               gs_limit_field:32'hfff, valid:1'b1, default:'0};
    rcp_in = '{base_addr:64'h10_0000, feature_mask:64'h7, wide_mode_attribute:wide,
               cfp_enabled:1'b1, default:'0};
    arch_in = '{wide_mode:wide, legacy_float_save_enable:1'b1, extended_save_enable:1'b1,
                enabled_features_register:64'hf, cs_limit:32'hff_ffff, ds_limit:32'hff_ffff,
                trap_flag:1'b1, stack_ptr:64'h7000, frame_ptr:64'h7100, fs_base:64'h11,
                gs_base:64'h22, default:'0};
    pchk_in = '{tcp_page_ok:1'b1, frame_pages_ok:1'b1, cfp_frame_ok:1'b1, default:'0};
    reg_b_in = 64'h5000;
  endtask

  task automatic mutate(int i);
    case (i)
      0: reg_b_in = 64'h5008;
      1: tcp_in.valid = 1'b0;
      2: tcp_in.busy = 1'b1;
      3: rcp_in.in_use = 1'b1;
      4: tcp_in.flags_reserved = 64'h1;
      5: arch_in.wide_mode = 1'b0;
      6: arch_in.legacy_float_save_enable = 1'b0;
      7: arch_in.extended_save_enable = 1'b0;
      8: arch_in.enabled_features_register = 64'h3;
      9: tcp_in.exit_notify_flag = 1'b1;
      10: pchk_in.tcp_conflict = 1'b1;
      11: rcp_in.base_addr = 64'h0000_8000_0000_0000;
      12: arch_in.seg_bases_nonzero = 1'b1;
      13: tcp_in.entry_offset = 64'hff_0000;
      14: tcp_in.fs_limit_field = 32'hff_0000;
      15: arch_in.region_mode = 1'b0;
      16: tcp_in.save_frame_index = 32'h0;
      17: pchk_in.frame_pages_ok = 1'b0;
      default: pchk_in.cfp_frame_ok = 1'b0;
    endcase
  endtask

  // Holds drain low d edges and the enable low f edges after issue
  task automatic run(logic [7:0] code, int d, int f);
    leaf_code_in = code;
    drained_in = (d == 0);
    issue_in = 1'b1;
    @(posedge sys_clk_in);
    #1 issue_in = 1'b0;
    for (k = 1; k < 40 && done_out !== 1'b1; k++) begin
      drained_in = (k > d);
      clk_en_in = (k > f);
      @(posedge sys_clk_in);
      #1;
    end
    clk_en_in = 1'b1;
    if (done_out !== 1'b1) begin
      mismatches++;
      close_out();
    end
  endtask

  task automatic do_reset();
    rst_in = 1'b1;
    repeat (2) @(posedge sys_clk_in);
    #1 rst_in = 1'b0;
  endtask

  initial begin
    mismatches = 0;
    checks_done = 0;
    defaults(1'b1);
    {issue_in, clk_en_in, drained_in, leaf_code_in} = {3'b011, 8'h00};
    {reg_c_in, next_ip_in} = {64'h9000, 64'h400};
    do_reset();
    check({done_out, region_mode_out, ip_out, perf_status_out}, 0);
    for (int i = 0; i < 19; i++) begin
      defaults(i < 12);
      arch_in.region_mode = (i > 14);
      mutate(i);
      run(i > 14 ? srent_pkg::LEAF_SAVE_DEC : srent_pkg::LEAF_ENTRY, i % 3, i % 2);
      check(k, (i % 3 > i % 2 ? i % 3 : i % 2) + 2);
      if (fexp[i] == 0) check(fault_out != srent_pkg::SRENT_FLT_NONE, 1'b1);
      else check(fault_out, srent_pkg::srent_fault_t'(fexp[i]));
      check({region_mode_out, ip_out, tcp_aep_out, save_index_out}, 0);
      check(fault_code_out, srent_pkg::FAULT_CODE_ZERO);
    end
    defaults(1'b1);
    run(srent_pkg::LEAF_ENTRY, 0, 0);
    check({fault_out, region_mode_out, ip_out}, {srent_pkg::SRENT_FLT_NONE, 1'b1, 64'h10_0100});
    check({ret_a_out, ret_c_out, tcp_aep_out}, {64'h1, 64'h400, 64'h9000});
    check({saved_sp_out, saved_bp_out, saved_xfeat_out, xfeat_out}, {64'h7000, 64'h7100, 64'hf, 64'h7});
    check({saved_fs_out, saved_gs_out, new_fs_out, new_gs_out}, {64'h11, 64'h22, 64'h10_1000, 64'h10_2000});
    check({saved_tf_out, trap_flag_out, step_pend_out, opt_out_out, bp_sup_out_out}, 5'h13);
    check({bp_sup_in_out, perf_sup_out, precise_event_sampling_sup_out, demote_other_out}, 4'hf);
    check({perf_status_out[63], perf_status_out[60]}, 2'b11);
    @(posedge sys_clk_in);
    #1 check(trap_flag_out, 1'b0);
    leaf_code_in = 8'h05;
    issue_in = 1'b1;
    @(posedge sys_clk_in);
    #1 issue_in = 1'b0;
    repeat (4) begin
      @(posedge sys_clk_in);
      #1 check(done_out, 1'b0);
    end
    {arch_in.region_mode, tcp_in.save_frame_index, rcp_in.cfp_enabled} = {1'b1, 32'h3, 1'b0};
    pchk_in.cfp_frame_ok = 1'b0;
    run(srent_pkg::LEAF_SAVE_DEC, 1, 0);
    check({fault_out, save_index_out}, {srent_pkg::SRENT_FLT_NONE, 32'h2});
    do_reset();
    defaults(1'b0);
    {tcp_in.debug_opt_in_flag, tcp_in.exit_notify_flag} = 2'b11;
    {arch_in.extended_save_enable, rcp_in.feature_mask} = {1'b0, 64'h3};
    run(srent_pkg::LEAF_ENTRY, 0, 0);
    check({fault_out, region_mode_out, step_pend_out, opt_out_out}, 5'h6);
    check({bp_sup_out_out, bp_sup_in_out, perf_sup_out}, 3'h4);
    check({new_fs_out, new_fs_limit_out, new_gs_limit_out}, {64'h10_1000, 64'hfff_0000_0fff});
    @(posedge sys_clk_in);
    #1 check(step_pend_out, 1'b0);
    close_out();
  end
endmodule
